// [shared/scp_pkg.sv]
// package of the serializer configuration bank: register map, reset values,
// field positions, timing counts and the state types of the design.
// assumes a 100 MHz system clock that samples every pin, pixel clock included.
//
// Notes on behaviour
// - vsync polarity bit affects dither input only
// - transpose bit alternates dither pattern per frame
// - temporal dither bit switches temporal dithering
// - dither parameter resets to recommended default value
// - colour-depth bit: 24-bit or 18-bit, resets 18
// - drive level field, 00 large swing, resets 00
// - only all-ones device select enables the port
// - protected registers need unlock; they read back nothing
// - reserved bits written zero, read back unmasked
// - soft reset bit holds the device in reset
// - three-wire read: host eight bits, device eight
// - link clock six or eight times pixel clock
// - power-down pin low: sleep, registers to defaults
// - static pixel clock sleeps, restart wakes device
// - clock-stop sleep keeps registers and lookup ram
// - power-up clears lookup ram, registers to defaults
// - lanes carry data on both link clock edges
// - command bit four unlocks protected registers, resets zero
// - dither control bit zero bypasses dithering
// - write frame: zero, seven address, eight data bits
package scp_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_COMMAND = 7'h00;
   localparam logic [6:0] ADDR_DITHER_CONTROL = 7'h08;
   localparam logic [6:0] ADDR_DITHER_PARAMETER = 7'h09;
   localparam logic [6:0] ADDR_MODE_AND_RESET = 7'h0b;
   localparam logic [6:0] ADDR_PORT_SELECT = 7'h16;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_COMMAND = 8'h00;
   localparam logic [7:0] RST_DITHER_CONTROL = 8'h65;
   localparam logic [7:0] RST_DITHER_PARAMETER = 8'h67;
   localparam logic [7:0] RST_MODE_AND_RESET = 8'h00;
   localparam logic [7:0] RST_PORT_SELECT = 8'h00;
   localparam logic [7:0] PORT_ENABLE_CODE = 8'hff;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CMD_LUT_ENABLE = 0;
   localparam int CMD_UNLOCK = 4;
   localparam int DC_BYPASS = 0;
   localparam int DC_ENABLE_INV = 1;
   localparam int DC_VSYNC_INV = 2;
   localparam int DC_TRANSPOSE = 4;
   localparam int DC_TEMPORAL = 5;
   localparam int DC_AMPLITUDE = 6;
   localparam int MR_MODE24 = 0;
   localparam int MR_SOFT_RESET = 1;
   localparam int MR_DRIVE_LO = 4;
   localparam int MR_DRIVE_HI = 5;
   localparam int FRAME_READ_BIT = 7;
   // ----------------------------------------------------------------
   // link and timing figures
   // ----------------------------------------------------------------
   localparam logic [3:0] MULT_18BIT = 4'h6;
   localparam logic [3:0] MULT_24BIT = 4'h8;
   localparam logic [1:0] BITS_PER_LINK_CLOCK = 2'h2;
   localparam int SYS_CLOCK_NS = 10;
   localparam int PCLK_STOP_DETECT_NS = 160;
   localparam int PCLK_STOP_CYCLES = PCLK_STOP_DETECT_NS / SYS_CLOCK_NS;
   // ----------------------------------------------------------------
   // state types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SPI_IDLE = 2'h0,
      SPI_HEADER = 2'h1,
      SPI_WRITE = 2'h3,
      SPI_READ = 2'h2
   } scp_spi_type;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } scp_sync_type;

   typedef struct packed {
      scp_spi_type fsm;
      logic [2:0] bit_count;
      logic [7:0] shift;
      logic [6:0] addr;
      logic [7:0] command;
      logic [7:0] dither_control;
      logic [7:0] dither_parameter;
      logic [7:0] mode_and_reset_config;
      logic [7:0] port_select_lock;
      logic sclk_d;
      logic pclk_d;
      logic [7:0] idle_count;
      logic stopped;
      logic sleep;
      logic hold;
      logic [3:0] mult;
      logic [1:0] lane_bits;
      logic lut_clear;
      logic dout;
      logic doe;
   } scp_state_type;
endpackage

// [shared/scp_pin_if.sv]
// interface carrying the synchronised pin levels from the synchronisers
// to the register bank logic; all signals on the system clock.
`timescale 1ns/1ns
interface scp_pin_if;
   logic sclk;
   logic csn;
   logic din;
   logic pclk;
   logic pdn;
   modport sync_side (output sclk, csn, din, pclk, pdn);
   modport core (input sclk, csn, din, pclk, pdn);
endinterface

// [hw/scp_sync.sv]
// three-flop pin synchroniser; the output moves only when the second and
// third stages agree. assumes clk is the system clock.
`timescale 1ns/1ns
module scp_sync
   import scp_pkg::*;
#(
   parameter logic INIT = 1'b0
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic raw,
   output logic q
);
   scp_sync_type st;
   scp_sync_type next_st;

   always_comb begin
      next_st.s1 = raw;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // agreement of stages two and three filters a metastable resolve
      next_st.q = (st.s2 == st.s3) ? st.s3 : st.q;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st <= {INIT, INIT, INIT, INIT};
      end else begin
         st <= next_st;
      end
   end

   assign q = st.q;
endmodule

// [hw/scp_top.sv]
// configuration register bank and power control of the rgb serializer.
// assumes all pins are asynchronous to clk; the spi clock must stay well
// below a quarter of clk so that each of its edges is seen.
`timescale 1ns/1ns
module scp_top
   import scp_pkg::*;
#(
   parameter int STOP_CYCLES = PCLK_STOP_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic spi_sclk,
   input wire logic config_select_n,
   input wire logic config_data_in,
   output logic config_data_out,
   output logic config_data_oe,
   input wire logic pixel_clock,
   input wire logic power_down_pin_n,
   output logic dither_bypass,
   output logic enable_polarity_invert,
   output logic vsync_polarity_invert,
   output logic frame_pattern_transpose,
   output logic temporal_dither_on,
   output logic dither_amplitude_select,
   output logic [7:0] dither_parameter,
   output logic lut_enable,
   output logic mode_24bit,
   output logic [1:0] drive_level,
   output logic soft_reset_bit,
   output logic core_hold_reset,
   output logic sleep_state,
   output logic [3:0] pll_multiplier,
   output logic [1:0] lane_bits_per_clock,
   output logic lut_clear
);
   // ----------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------
   // the count must outlast a pixel clock half period and fit the counter
   if (STOP_CYCLES < 8 || STOP_CYCLES > 255) begin : g_bad_stop
      $error("STOP_CYCLES must lie between 8 and 255");
   end

   localparam logic [7:0] STOP_LAST = 8'(STOP_CYCLES - 1);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   scp_pin_if pins();

   scp_sync #(.INIT(1'b0)) u_sclk (
      .clk(clk),
      .reset(reset),
      .raw(spi_sclk),
      .q(pins.sclk)
   );
   scp_sync #(.INIT(1'b1)) u_csn (
      .clk(clk),
      .reset(reset),
      .raw(config_select_n),
      .q(pins.csn)
   );
   scp_sync #(.INIT(1'b0)) u_din (
      .clk(clk),
      .reset(reset),
      .raw(config_data_in),
      .q(pins.din)
   );
   scp_sync #(.INIT(1'b0)) u_pclk (
      .clk(clk),
      .reset(reset),
      .raw(pixel_clock),
      .q(pins.pclk)
   );
   scp_sync #(.INIT(1'b1)) u_pdn (
      .clk(clk),
      .reset(reset),
      .raw(power_down_pin_n),
      .q(pins.pdn)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   scp_state_type st;
   scp_state_type next_st;
   logic rise;
   logic fall;
   logic [7:0] byte_in;
   logic do_write;
   logic [6:0] wr_addr;
   logic port_open;
   logic unlocked;

   function automatic logic [7:0] read_value(
      input scp_state_type s,
      input logic [6:0] a
   );
      logic [7:0] v;
      v = 8'h00;
      // protected registers are write only; unmapped reads give zero
      case (a)
         ADDR_COMMAND: v = s.command;
         ADDR_PORT_SELECT: v = s.port_select_lock;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      do_write = 1'b0;
      wr_addr = st.addr;
      rise = pins.sclk & ~st.sclk_d;
      fall = ~pins.sclk & st.sclk_d;
      byte_in = {st.shift[6:0], pins.din};
      port_open = (st.port_select_lock == PORT_ENABLE_CODE);
      unlocked = st.command[CMD_UNLOCK];
      next_st.sclk_d = pins.sclk;
      next_st.pclk_d = pins.pclk;
      next_st.lut_clear = 1'b0;

      // pixel clock watchdog: any edge restarts the count and wakes up
      if (pins.pclk != st.pclk_d) begin
         next_st.idle_count = 8'h00;
         next_st.stopped = 1'b0;
      end else if (st.idle_count == STOP_LAST) begin
         next_st.stopped = 1'b1;
      end else begin
         next_st.idle_count = st.idle_count + 8'h01;
      end

      // serial frame receiver
      if (pins.csn) begin
         next_st.fsm = SPI_IDLE;
         next_st.bit_count = 3'h0;
         next_st.doe = 1'b0;
      end else begin
         case (st.fsm)
            SPI_IDLE, SPI_HEADER: begin
               next_st.fsm = SPI_HEADER;
               if (rise) begin
                  next_st.shift = byte_in;
                  next_st.bit_count = st.bit_count + 3'h1;
                  if (st.bit_count == 3'h7) begin
                     next_st.addr = byte_in[6:0];
                     if (byte_in[FRAME_READ_BIT]) begin
                        next_st.fsm = SPI_READ;
                        next_st.shift = read_value(st, byte_in[6:0]);
                     end else begin
                        next_st.fsm = SPI_WRITE;
                     end
                  end
               end
            end
            SPI_WRITE: begin
               if (rise) begin
                  next_st.shift = byte_in;
                  next_st.bit_count = st.bit_count + 3'h1;
                  if (st.bit_count == 3'h7) begin
                     // page write: stay here and step the address
                     do_write = 1'b1;
                     next_st.addr = st.addr + 7'h01;
                  end
               end
            end
            SPI_READ: begin
               // the host has let go of the line after its eight bits
               if (fall) begin
                  next_st.doe = port_open;
                  next_st.dout = st.shift[7];
                  next_st.shift = {st.shift[6:0], 1'b0};
               end
            end
            default: begin
               next_st.fsm = SPI_IDLE;
            end
         endcase
      end

      // register writes; reserved addresses are simply not decoded
      if (do_write && (port_open || wr_addr == ADDR_PORT_SELECT)) begin
         case (wr_addr)
            ADDR_COMMAND: next_st.command = byte_in;
            ADDR_DITHER_CONTROL: begin
               if (unlocked) begin
                  next_st.dither_control = byte_in;
               end
            end
            ADDR_DITHER_PARAMETER: begin
               if (unlocked) begin
                  next_st.dither_parameter = byte_in;
               end
            end
            ADDR_MODE_AND_RESET: begin
               if (unlocked) begin
                  next_st.mode_and_reset_config = byte_in;
               end
            end
            ADDR_PORT_SELECT: next_st.port_select_lock = byte_in;
            default: begin
               next_st.command = next_st.command;
            end
         endcase
      end

      // power-down pin: registers fall back, lookup ram is left alone
      if (!pins.pdn) begin
         next_st.command = RST_COMMAND;
         next_st.dither_control = RST_DITHER_CONTROL;
         next_st.dither_parameter = RST_DITHER_PARAMETER;
         next_st.mode_and_reset_config = RST_MODE_AND_RESET;
         next_st.port_select_lock = RST_PORT_SELECT;
         next_st.fsm = SPI_IDLE;
         next_st.bit_count = 3'h0;
         next_st.doe = 1'b0;
      end

      // clock-stop sleep only gates the core; registers are kept
      next_st.sleep = ~pins.pdn | st.stopped;
      next_st.hold = st.mode_and_reset_config[MR_SOFT_RESET] | st.sleep;
      next_st.mult = st.mode_and_reset_config[MR_MODE24] ? MULT_24BIT : MULT_18BIT;
      next_st.lane_bits = BITS_PER_LINK_CLOCK;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st.fsm <= SPI_IDLE;
         st.bit_count <= 3'h0;
         st.shift <= 8'h00;
         st.addr <= 7'h00;

         st.command <= RST_COMMAND;
         st.dither_control <= RST_DITHER_CONTROL;
         st.dither_parameter <= RST_DITHER_PARAMETER;
         st.mode_and_reset_config <= RST_MODE_AND_RESET;
         st.port_select_lock <= RST_PORT_SELECT;

         st.sclk_d <= 1'b0;
         st.pclk_d <= 1'b0;
         st.idle_count <= 8'h00;
         st.stopped <= 1'b0;

         st.sleep <= 1'b0;
         st.hold <= 1'b1;

         st.mult <= MULT_18BIT;
         st.lane_bits <= BITS_PER_LINK_CLOCK;
         st.lut_clear <= 1'b1;
         st.dout <= 1'b0;
         st.doe <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign config_data_out = st.dout;
   assign config_data_oe = st.doe;

   assign dither_bypass = st.dither_control[DC_BYPASS];
   assign enable_polarity_invert = st.dither_control[DC_ENABLE_INV];
   // only the dither input sees this; the sync output is untouched
   assign vsync_polarity_invert = st.dither_control[DC_VSYNC_INV];
   assign frame_pattern_transpose = st.dither_control[DC_TRANSPOSE];
   assign temporal_dither_on = st.dither_control[DC_TEMPORAL];
   assign dither_amplitude_select = st.dither_control[DC_AMPLITUDE];
   assign dither_parameter = st.dither_parameter;
   assign lut_enable = st.command[CMD_LUT_ENABLE];

   assign mode_24bit = st.mode_and_reset_config[MR_MODE24];
   assign drive_level = st.mode_and_reset_config[MR_DRIVE_HI:MR_DRIVE_LO];
   assign soft_reset_bit = st.mode_and_reset_config[MR_SOFT_RESET];
   assign core_hold_reset = st.hold;
   assign sleep_state = st.sleep;
   assign pll_multiplier = st.mult;
   assign lane_bits_per_clock = st.lane_bits;
   assign lut_clear = st.lut_clear;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   chk_mult_follow: assert property (
      ##1 pll_multiplier == ($past(st.mode_and_reset_config[MR_MODE24]) ? 4'h8 : 4'h6))
      else $error("pll multiplier does not follow colour depth");

   chk_pin_defaults: assert property (
      !pins.pdn |=> st.port_select_lock == 8'h00 && dither_parameter == 8'h67
                    && st.mode_and_reset_config == 8'h00 && !config_data_oe)
      else $error("registers not at defaults under power-down pin");

   chk_stop_sleep: assert property (
      $stable(pins.pclk) [*8] ##0 (st.idle_count == STOP_LAST) |-> ##[1:2] st.stopped)
      else $error("static pixel clock not detected");

   chk_restart_wake: assert property (
      pins.pdn && (pins.pclk != st.pclk_d) ##1 pins.pdn |-> !st.stopped ##1 !sleep_state)
      else $error("pixel clock restart did not wake");

   chk_stop_retain: assert property (
      st.stopped && pins.pdn && !do_write |=> $stable(st.mode_and_reset_config)
                                             && $stable(st.command))
      else $error("registers changed in clock-stop sleep");

   chk_locked_ignore: assert property (
      do_write && !st.command[CMD_UNLOCK] && pins.pdn
      |=> $stable(st.dither_control) && $stable(st.dither_parameter)
          && $stable(st.mode_and_reset_config))
      else $error("protected register written while locked");

   chk_read_gate: assert property (
      config_data_oe |-> st.port_select_lock == 8'hff && st.fsm == SPI_READ)
      else $error("data line driven without port enable");

   chk_header_quiet: assert property (
      st.fsm == SPI_HEADER |-> !config_data_oe)
      else $error("device drove line during host bits");

   chk_soft_hold: assert property (
      st.mode_and_reset_config[MR_SOFT_RESET] |=> core_hold_reset)
      else $error("soft reset bit did not hold the core");

   chk_lut_clear: assert property (
      lut_clear |=> !lut_clear [*2])
      else $error("lookup clear lasted past power-up");

   chk_vsync_local: assert property (
      lane_bits_per_clock == 2'h2 && (!$changed(vsync_polarity_invert) || $past(!pins.pdn)
         || $past(do_write && port_open && unlocked && wr_addr == ADDR_DITHER_CONTROL)))
      else $error("vsync polarity select changed without a write");

   cov_page_write: cover property (do_write ##[1:300] do_write);
   cov_read_frame: cover property ($rose(config_data_oe));
   cov_stop_sleep: cover property ($rose(st.stopped) ##[1:1000] $fell(st.stopped));
endmodule

// [testbench/scp_host_model.sv]
// spi host and pixel clock source in front of the configuration bank.
// assumes clk at 100 MHz; every host-driven spi pin change lands on a falling clk edge.
`timescale 1ns/1ns
module scp_host_model (
   input wire logic clk,
   input wire logic pixel_run,
   input wire logic config_data_out,
   input wire logic config_data_oe,
   output logic spi_sclk,
   output logic config_select_n,
   output logic config_data_in,
   output logic pixel_clock
);
   logic host_oe;
   logic host_bit;
   logic last_level;
   logic oe_seen;
   // ----------------------------------------------------------------
   // shared data line
   // ----------------------------------------------------------------
   // no pull on the line: once released it toggles, so stale data cannot pass
   assign config_data_in = config_data_oe ? config_data_out : (host_oe ? host_bit : ~last_level);
   always @(negedge clk) last_level <= config_data_in;
   always @(posedge clk) begin
      if (config_select_n) oe_seen <= 1'b0;
      else if (config_data_oe === 1'b1) oe_seen <= 1'b1;
   end
   initial begin
      spi_sclk = 1'b0;
      config_select_n = 1'b1;
      host_oe = 1'b1;
      host_bit = 1'b0;
      pixel_clock = 1'b0;
      // phase offset keeps the pixel clock unrelated to clk
      #3;
      forever begin
         #40;
         if (pixel_run) pixel_clock = ~pixel_clock;
      end
   end
   // ----------------------------------------------------------------
   // frame tasks
   // ----------------------------------------------------------------
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic shift_bit(input logic b, input logic drive, output logic seen);
      spi_sclk = 1'b0;
      host_oe = drive;
      host_bit = b;
      wait_clk(8);
      seen = config_data_in;
      spi_sclk = 1'b1;
      wait_clk(8);
   endtask
   task automatic send_byte(input logic [7:0] b, input logic drive, output logic [7:0] seen);
      for (int i = 7; i >= 0; i--) shift_bit(b[i], drive, seen[i]);
   endtask
   task automatic open_frame();
      config_select_n = 1'b0;
      wait_clk(8);
   endtask
   task automatic close_frame();
      config_select_n = 1'b1;
      host_oe = 1'b1;
      wait_clk(12);
   endtask
   // only documented addresses are ever written
   task automatic write_reg(input logic [6:0] addr, input logic [7:0] d);
      logic [7:0] junk;
      open_frame();
      send_byte({1'b0, addr}, 1'b1, junk);
      send_byte(d, 1'b1, junk);
      close_frame();
   endtask
   task automatic write_page(input logic [6:0] addr, input logic [15:0] d);
      logic [7:0] junk;
      open_frame();
      send_byte({1'b0, addr}, 1'b1, junk);
      send_byte(d[15:8], 1'b1, junk);
      send_byte(d[7:0], 1'b1, junk);
      close_frame();
   endtask
   task automatic read_reg(input logic [6:0] addr, output logic [7:0] d, output logic driven);
      logic [7:0] junk;
      open_frame();
      send_byte({1'b1, addr}, 1'b1, junk);
      send_byte(8'h00, 1'b0, d);
      driven = oe_seen;
      close_frame();
   endtask
endmodule

// [testbench/scp_top_tb.sv]
// self-checking bench of the configuration bank, driven through the host model.
// assumes the host model of scp_host_model.sv and the default stop count.
`timescale 1ns/1ns
module scp_top_tb;
   import scp_pkg::*;
   logic clk, reset, power_down_pin_n, pixel_run, spi_sclk, config_select_n;
   logic config_data_in, config_data_out, config_data_oe, pixel_clock;
   logic dither_bypass, enable_polarity_invert, vsync_polarity_invert;
   logic frame_pattern_transpose, temporal_dither_on, dither_amplitude_select;
   logic [7:0] dither_parameter;
   logic lut_enable, mode_24bit, soft_reset_bit, core_hold_reset, sleep_state, lut_clear;
   logic [1:0] drive_level, lane_bits_per_clock;
   logic [3:0] pll_multiplier;
   logic [7:0] rd;
   logic drv;
   int failures, check_count;
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   scp_host_model host (.clk(clk), .pixel_run(pixel_run), .config_data_out(config_data_out),
      .config_data_oe(config_data_oe), .spi_sclk(spi_sclk), .config_select_n(config_select_n),
      .config_data_in(config_data_in), .pixel_clock(pixel_clock));
   scp_top dut (.clk(clk), .reset(reset), .spi_sclk(spi_sclk),
      .config_select_n(config_select_n), .config_data_in(config_data_in),
      .config_data_out(config_data_out), .config_data_oe(config_data_oe),
      .pixel_clock(pixel_clock), .power_down_pin_n(power_down_pin_n),
      .dither_bypass(dither_bypass), .enable_polarity_invert(enable_polarity_invert),
      .vsync_polarity_invert(vsync_polarity_invert),
      .frame_pattern_transpose(frame_pattern_transpose),
      .temporal_dither_on(temporal_dither_on),
      .dither_amplitude_select(dither_amplitude_select), .dither_parameter(dither_parameter),
      .lut_enable(lut_enable), .mode_24bit(mode_24bit), .drive_level(drive_level),
      .soft_reset_bit(soft_reset_bit), .core_hold_reset(core_hold_reset),
      .sleep_state(sleep_state), .pll_multiplier(pll_multiplier),
      .lane_bits_per_clock(lane_bits_per_clock), .lut_clear(lut_clear));
   // ----------------------------------------------------------------
   // compare and report
   // ----------------------------------------------------------------
   task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] seen);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic check_flag(input string what, input logic exp, input logic seen);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %b seen %b", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic check_defaults();
      check_flag("bypass", 1'b1, dither_bypass);
      check_flag("enable_inv", 1'b0, enable_polarity_invert);
      check_flag("vsync_inv", 1'b1, vsync_polarity_invert);
      check_flag("transpose", 1'b0, frame_pattern_transpose);
      check_flag("temporal", 1'b1, temporal_dither_on);
      check_flag("amplitude", 1'b1, dither_amplitude_select);
      check_val("parameter", RST_DITHER_PARAMETER, dither_parameter);
      check_flag("mode24", 1'b0, mode_24bit);
      check_val("drive", 8'h00, {6'h00, drive_level});
      check_flag("soft", 1'b0, soft_reset_bit);
      check_flag("lut_enable", 1'b0, lut_enable);
      check_val("mult", 8'h06, {4'h0, pll_multiplier});
      host.read_reg(ADDR_COMMAND, rd, drv);
      check_flag("port closed", 1'b0, drv);
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      final_report();
   end
   initial begin
      failures = 0;
      check_count = 0;
      reset = 1'b1;
      power_down_pin_n = 1'b1;
      pixel_run = 1'b1;
      repeat (20) @(negedge clk);
      check_flag("lut_clear reset", 1'b1, lut_clear);
      reset = 1'b0;
      repeat (3) @(negedge clk);
      check_flag("lut_clear idle", 1'b0, lut_clear);
      check_val("lane bits", 8'h02, {6'h00, lane_bits_per_clock});
      check_defaults();
      // port closed: writes other than the select register are dropped
      host.write_reg(ADDR_COMMAND, 8'h10);
      host.write_reg(ADDR_PORT_SELECT, 8'hfe);
      host.read_reg(ADDR_COMMAND, rd, drv);
      check_flag("fe closed", 1'b0, drv);
      host.write_reg(ADDR_PORT_SELECT, PORT_ENABLE_CODE);
      host.read_reg(ADDR_PORT_SELECT, rd, drv);
      check_flag("ff open", 1'b1, drv);
      check_val("select", 8'hff, rd);
      host.read_reg(ADDR_COMMAND, rd, drv);
      check_val("command", 8'h00, rd);
      host.write_reg(ADDR_DITHER_CONTROL, 8'h12);
      check_flag("locked write", 1'b1, dither_bypass);
      host.write_reg(ADDR_COMMAND, 8'h11);
      host.read_reg(ADDR_COMMAND, rd, drv);
      check_val("unlock", 8'h11, rd);
      check_flag("lut on", 1'b1, lut_enable);
      // page write: second byte lands at the next address
      host.write_page(ADDR_DITHER_CONTROL, 16'h123c);
      check_flag("bypass off", 1'b0, dither_bypass);
      check_flag("enable inv", 1'b1, enable_polarity_invert);
      check_flag("vsync inv", 1'b0, vsync_polarity_invert);
      check_flag("transpose on", 1'b1, frame_pattern_transpose);
      check_flag("temporal off", 1'b0, temporal_dither_on);
      check_flag("amp four", 1'b0, dither_amplitude_select);
      check_val("param page", 8'h3c, dither_parameter);
      host.read_reg(ADDR_DITHER_CONTROL, rd, drv);
      check_val("write only", 8'h00, rd);
      host.write_reg(ADDR_MODE_AND_RESET, 8'h13);
      repeat (3) @(negedge clk);
      check_flag("mode24 on", 1'b1, mode_24bit);
      check_val("drive low", 8'h01, {6'h00, drive_level});
      check_val("mult 8", 8'h08, {4'h0, pll_multiplier});
      check_flag("soft on", 1'b1, soft_reset_bit);
      check_flag("hold on", 1'b1, core_hold_reset);
      host.write_reg(ADDR_MODE_AND_RESET, 8'h11);
      check_flag("hold off", 1'b0, core_hold_reset);
      check_val("kept param", 8'h3c, dither_parameter);
      // pixel clock held static for six periods
      pixel_run = 1'b0;
      repeat (48) @(negedge clk);
      check_flag("stop sleep", 1'b1, sleep_state);
      check_val("stop param", 8'h3c, dither_parameter);
      check_flag("stop mode", 1'b1, mode_24bit);
      check_flag("stop lut", 1'b0, lut_clear);
      pixel_run = 1'b1;
      repeat (30) @(negedge clk);
      check_flag("wake", 1'b0, sleep_state);
      host.read_reg(ADDR_COMMAND, rd, drv);
      check_val("kept command", 8'h11, rd);
      power_down_pin_n = 1'b0;
      repeat (10) @(negedge clk);
      check_flag("pin sleep", 1'b1, sleep_state);
      check_flag("pin lut", 1'b0, lut_clear);
      check_val("pin param", 8'h67, dither_parameter);
      power_down_pin_n = 1'b1;
      repeat (10) @(negedge clk);
      check_defaults();
      host.write_reg(ADDR_PORT_SELECT, PORT_ENABLE_CODE);
      reset = 1'b1;
      repeat (2) @(negedge clk);
      check_flag("lut_clear again", 1'b1, lut_clear);
      reset = 1'b0;
      repeat (3) @(negedge clk);
      check_defaults();
      final_report();
   end
endmodule
